/* shared/gflm_consts.svh */
// Constants for the fault supervision and ground-loss monitor.
// Assumes inclusion by the package and design files by bare name.
`ifndef GFLM_CONSTS_SVH
`define GFLM_CONSTS_SVH

`define GFLM_MCLK_MHZ 125
`define GFLM_OSC_MHZ 4
`define GFLM_ACC_W 8
`define GFLM_HOLD_CAPACITOR_NODE_SUST_US 1000
`define GFLM_FRAME_TO_US 1000
`define GFLM_TMR_W 18
`define GFLM_GF_W 14
`define GFLM_GF_TOP 14'h3fff
`define GFLM_GROUND_LOSS_ENABLE_BIT_BIT 5
`define GFLM_ACCEL_W 10
`define GFLM_ACCEL_ZERO 10'h000

`endif

/* shared/gflm_pkg.sv */
// Types for the fault supervision and ground-loss monitor.
// Assumes the constants header is on the include path.
`include "gflm_consts.svh"

package gflm_pkg;

  typedef enum logic [1:0] {
    GFLM_RUN = 2'b01,
    GFLM_HELD = 2'b10
  } gflm_pwr_t;

  typedef enum logic [1:0] {
    GFLM_CMD_OTHER = 2'h0,
    GFLM_CMD_SELFTEST_LOCKOUT = 2'h1,
    GFLM_CMD_STEN = 2'h2,
    GFLM_CMD_CLEAR = 2'h3
  } gflm_cmd_t;

  typedef struct packed {
    logic [`GFLM_GF_W-1:0] cnt;
    logic loss;
  } gflm_filt_t;

  typedef struct packed {
    gflm_pwr_t pwr;
    logic [`GFLM_ACC_W-1:0] acc;
    logic [`GFLM_TMR_W-1:0] hold_capacitor_node_cnt;
    logic [`GFLM_TMR_W-1:0] frame_cnt;
    logic prev_selftest_lockout;
    logic lockout;
    logic s_flag;
    logic gf_flag;
    logic u_flag;
    logic sw_closed;
    logic sdi;
    logic adc_pin;
    logic [`GFLM_ACCEL_W-1:0] accel;
  } gflm_state_t;

endpackage : gflm_pkg

/* design/gflm_gnd_filter.sv */
// Ground-loss up/down filter counter.
// Assumes a single clock and a one-cycle oscillator tick from the caller.
`timescale 1ns/10ps
`default_nettype none
`include "gflm_consts.svh"

module gflm_gnd_filter
  import gflm_pkg::*;
#(
  parameter logic [`GFLM_GF_W-1:0] GF_TOP = `GFLM_GF_TOP
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic en_i,
  input wire logic above_i,
  output logic [`GFLM_GF_W-1:0] cnt_o,
  output logic loss_o
);

  gflm_filt_t q;
  gflm_filt_t d;

  always_comb begin
    d = q;
    if (!en_i) begin
      d.cnt = '0;
      d.loss = 1'b0;
    end else if (tick_i) begin
      if (above_i) begin
        if (q.cnt == GF_TOP) begin
          d.loss = 1'b1;
        end else begin
          d.cnt = q.cnt + 1'b1;
        end
      end else if (q.cnt != '0) begin
        d.cnt = q.cnt - 1'b1;
      end else begin
        d.loss = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cnt_o = q.cnt;
  assign loss_o = q.loss;

  a_hold_at_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    en_i && tick_i && !above_i && q.cnt == '0 |=> q.cnt == '0)
    else $error("Filter counter wrapped below zero.");

  a_count_up_step: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    en_i && tick_i && above_i && q.cnt != GF_TOP |=> q.cnt == $past(q.cnt) + 1'b1)
    else $error("Filter counter did not count up.");

  a_count_down_step: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    en_i && tick_i && !above_i && q.cnt != '0 |=> q.cnt == $past(q.cnt) - 1'b1)
    else $error("Filter counter did not count down.");

  a_overflow_loss: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    en_i && tick_i && above_i && q.cnt == GF_TOP |=> q.loss && q.cnt == GF_TOP)
    else $error("Overflow did not declare ground loss.");

  a_disabled_idle: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !en_i |=> q.cnt == '0 && !q.loss)
    else $error("Filter active while disabled.");

endmodule : gflm_gnd_filter

`default_nettype wire

/* design/gflm_monitor.sv */
// Fault supervision: reset holding, status flags and reply forcing.
// Assumes all inputs are synchronous to mclk_i and rst_n_i is power-on reset.
`timescale 1ns/10ps
`default_nettype none
`include "gflm_consts.svh"

// Contract
// - Ground-loss detection runs only when bit 5 of config byte two is one.
// - Ground-loss detection is unavailable while the master uses differential mode.
// - Enabled detection with open ground counts the 14-bit filter counter up.
// - Ground voltage back below threshold makes the filter counter count down.
// - Filter counter overflow declares the ground-loss condition.
// - Filter timing derives from a nominal 4 MHz oscillator; hold capacitor and frame timers count mclk_i cycles.
// - Regulator output below minimum holds the device in reset, no transmission.
// - Regulated undervoltage: continuous reset, switch open, every bus command ignored.
// - Hold capacitor low over 1 ms: continuous reset, switch open, no replies.
// - Bus below frame threshold past frame timeout: continuous reset, switch open.
// - Hold capacitor low under 1 ms sets low-voltage flag, zeroes reply.
// - Fuse threshold failure sets overall fault flag and zeroes short-word reply.
// - Factory or customer parity failure sets fault flag and zeroes reply.
// - Ground loss past 4.096 ms sets fault and ground flags, zeroes reply.
// - Two consecutive disable self-test commands, nothing between, activate lockout.
// - Under lockout a latched fault clears only by Clear command or power-on.
// - In test mode the ground-sense pin is the test serial data input.
// - In test mode the filter monitor pin may drive the converter input.
module gflm_monitor
  import gflm_pkg::*;
#(
  parameter int HOLD_CAPACITOR_NODE_CYC = `GFLM_HOLD_CAPACITOR_NODE_SUST_US * `GFLM_MCLK_MHZ,
  parameter int FRAME_CYC = `GFLM_FRAME_TO_US * `GFLM_MCLK_MHZ,
  parameter logic [`GFLM_GF_W-1:0] GF_TOP = `GFLM_GF_TOP
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic test_mode_i,
  input wire logic diff_mode_i,
  input wire logic [7:0] config_byte_two_i,
  input wire logic ground_sense_pin_i,
  input wire logic filter_monitor_pin_adc_sel_i,
  input wire logic regulator_cap_node_uv_i,
  input wire logic hold_capacitor_node_uv_i,
  input wire logic bus_below_frame_i,
  input wire logic fuse_fault_i,
  input wire logic par1_fault_i,
  input wire logic par2_fault_i,
  input wire logic cmd_valid_i,
  input wire gflm_cmd_t cmd_code_i,
  input wire logic switch_close_i,
  input wire logic [`GFLM_ACCEL_W-1:0] accel_i,
  output logic [`GFLM_ACCEL_W-1:0] accel_o,
  output logic dev_reset_o,
  output logic cmd_ignore_o,
  output logic bus_switch_open_o,
  output logic low_voltage_flag_o,
  output logic status_flag_o,
  output logic ground_fault_flag_o,
  output logic selftest_lockout_o,
  output logic test_sdi_o,
  output logic adc_from_pin_o,
  output logic [`GFLM_GF_W-1:0] gnd_filter_cnt_o
);

  localparam logic [`GFLM_TMR_W-1:0] HOLD_CAPACITOR_NODE_LIM = `GFLM_TMR_W'(HOLD_CAPACITOR_NODE_CYC);
  localparam logic [`GFLM_TMR_W-1:0] FRAME_LIM = `GFLM_TMR_W'(FRAME_CYC);
  localparam logic [`GFLM_ACC_W-1:0] OSC_STEP = `GFLM_ACC_W'(`GFLM_OSC_MHZ);
  localparam logic [`GFLM_ACC_W-1:0] OSC_MOD = `GFLM_ACC_W'(`GFLM_MCLK_MHZ);

  gflm_state_t q;
  gflm_state_t d;

  logic osc_tick;
  logic [`GFLM_ACC_W-1:0] acc_sum;
  logic gld_en;
  logic gnd_loss;
  logic hold_capacitor_node_sust;
  logic frame_to;
  logic rst_cond;
  logic cmd_take;
  logic clear_req;
  logic fault_now;
  logic zero_reply;

  function automatic logic [`GFLM_TMR_W-1:0] sat_inc(
    input logic [`GFLM_TMR_W-1:0] cnt,
    input logic [`GFLM_TMR_W-1:0] lim,
    input logic run
  );
    logic [`GFLM_TMR_W-1:0] res;
    res = '0;
    if (run) begin
      res = (cnt == lim) ? cnt : cnt + 1'b1;
    end
    return res;
  endfunction : sat_inc

  // Fractional divider gives an average tick rate of exactly 4 MHz.
  assign acc_sum = q.acc + OSC_STEP;
  assign osc_tick = (acc_sum >= OSC_MOD);

  // Ground sensing is off in differential systems and when the pin is reused.
  assign gld_en = config_byte_two_i[`GFLM_GROUND_LOSS_ENABLE_BIT_BIT]
    & ~diff_mode_i
    & ~test_mode_i;

  gflm_gnd_filter #(
    .GF_TOP(GF_TOP)
  ) u_gnd_filter (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .tick_i(osc_tick),
    .en_i(gld_en),
    .above_i(ground_sense_pin_i),
    .cnt_o(gnd_filter_cnt_o),
    .loss_o(gnd_loss)
  );

  assign hold_capacitor_node_sust = (q.hold_capacitor_node_cnt == HOLD_CAPACITOR_NODE_LIM);
  assign frame_to = (q.frame_cnt == FRAME_LIM);
  assign rst_cond = regulator_cap_node_uv_i
    | (hold_capacitor_node_uv_i & hold_capacitor_node_sust)
    | (bus_below_frame_i & frame_to);

  assign cmd_take = cmd_valid_i & (q.pwr == GFLM_RUN) & ~rst_cond;
  assign clear_req = cmd_take & (cmd_code_i == GFLM_CMD_CLEAR);
  assign fault_now = fuse_fault_i
    | par1_fault_i | par2_fault_i
    | gnd_loss;

  always_comb begin
    d = q;
    zero_reply = 1'b0;
    d.acc = osc_tick ? (acc_sum - OSC_MOD) : acc_sum;
    d.hold_capacitor_node_cnt = sat_inc(q.hold_capacitor_node_cnt, HOLD_CAPACITOR_NODE_LIM, hold_capacitor_node_uv_i);
    d.frame_cnt = sat_inc(q.frame_cnt, FRAME_LIM, bus_below_frame_i);
    d.sdi = test_mode_i & ground_sense_pin_i;
    d.adc_pin = test_mode_i & filter_monitor_pin_adc_sel_i;
    case (q.pwr)
      GFLM_RUN: begin
        if (rst_cond) begin
          d.pwr = GFLM_HELD;
        end
      end
      GFLM_HELD: begin
        if (!rst_cond) begin
          d.pwr = GFLM_RUN;
        end
      end
      default: begin
        d.pwr = GFLM_HELD;
      end
    endcase
    if (rst_cond || q.pwr != GFLM_RUN) begin
      d.prev_selftest_lockout = 1'b0;
      d.lockout = 1'b0;
      d.s_flag = 1'b0;
      d.gf_flag = 1'b0;
      d.u_flag = 1'b0;
      d.sw_closed = 1'b0;
      d.accel = `GFLM_ACCEL_ZERO;
    end else begin
      if (cmd_take) begin
        d.prev_selftest_lockout = (cmd_code_i == GFLM_CMD_SELFTEST_LOCKOUT);
        if (cmd_code_i == GFLM_CMD_SELFTEST_LOCKOUT && q.prev_selftest_lockout) begin
          d.lockout = 1'b1;
        end
        if (switch_close_i) begin
          d.sw_closed = 1'b1;
        end
      end
      // A new fault wins over a clear in the same cycle.
      if (fault_now) begin
        d.s_flag = 1'b1;
      end else if (clear_req || !q.lockout) begin
        d.s_flag = 1'b0;
      end
      if (gnd_loss) begin
        d.gf_flag = 1'b1;
      end else if (clear_req || !q.lockout) begin
        d.gf_flag = 1'b0;
      end
      d.u_flag = hold_capacitor_node_uv_i;
      zero_reply = d.u_flag | d.s_flag | d.gf_flag;
      d.accel = zero_reply ? `GFLM_ACCEL_ZERO : accel_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.pwr <= GFLM_HELD;
    end else begin
      q <= d;
    end
  end

  assign dev_reset_o = (q.pwr == GFLM_HELD);
  assign cmd_ignore_o = (q.pwr == GFLM_HELD) | rst_cond;
  assign bus_switch_open_o = ~q.sw_closed;
  assign low_voltage_flag_o = q.u_flag;
  assign status_flag_o = q.s_flag;
  assign ground_fault_flag_o = q.gf_flag;
  assign selftest_lockout_o = q.lockout;
  assign test_sdi_o = q.sdi;
  assign adc_from_pin_o = q.adc_pin;
  assign accel_o = q.accel;

  a_regulator_cap_node_reset_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    regulator_cap_node_uv_i |=> dev_reset_o && bus_switch_open_o)
    else $error("Regulator undervoltage did not hold reset.");

  a_held_no_reply: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    dev_reset_o |-> accel_o == `GFLM_ACCEL_ZERO && cmd_ignore_o && !selftest_lockout_o)
    else $error("Device active while held in reset.");

  a_hold_capacitor_node_sustained: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    hold_capacitor_node_uv_i && hold_capacitor_node_sust |=> dev_reset_o)
    else $error("Sustained hold capacitor undervoltage not reset.");

  a_hold_capacitor_node_timer: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !hold_capacitor_node_uv_i |=> q.hold_capacitor_node_cnt == '0)
    else $error("Hold capacitor timer not restarted.");

  a_frame_timeout: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    bus_below_frame_i && frame_to |=> dev_reset_o && bus_switch_open_o)
    else $error("Frame timeout did not reset the device.");

  a_uv_flag_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    hold_capacitor_node_uv_i && !rst_cond && q.pwr == GFLM_RUN
    |=> low_voltage_flag_o && accel_o == `GFLM_ACCEL_ZERO && !dev_reset_o)
    else $error("Transient undervoltage handling wrong.");

  a_fault_sets_s: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (fuse_fault_i || par1_fault_i || par2_fault_i) && !rst_cond && q.pwr == GFLM_RUN
    |=> status_flag_o && accel_o == `GFLM_ACCEL_ZERO)
    else $error("Fuse or parity fault did not set status.");

  a_ground_flags: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    gnd_loss && !rst_cond && q.pwr == GFLM_RUN
    |=> status_flag_o && ground_fault_flag_o && accel_o == `GFLM_ACCEL_ZERO)
    else $error("Ground loss did not set both flags.");

  a_ground_diff_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    diff_mode_i |=> gnd_filter_cnt_o == '0 && !gnd_loss)
    else $error("Ground detection active in differential mode.");

  a_lockout_pair: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(selftest_lockout_o) |-> $past(cmd_take) && $past(cmd_code_i) == GFLM_CMD_SELFTEST_LOCKOUT
    && $past(q.prev_selftest_lockout))
    else $error("Lockout set without two disable commands.");

  a_latched_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    status_flag_o && selftest_lockout_o && !clear_req && !rst_cond && q.pwr == GFLM_RUN
    |=> status_flag_o)
    else $error("Latched fault cleared under lockout.");

  a_reply_pass: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !dev_reset_o && !$past(dev_reset_o) && !low_voltage_flag_o && !status_flag_o
    && !ground_fault_flag_o |-> accel_o == $past(accel_i))
    else $error("Reply forced without an active fault.");

  a_test_sdi: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    test_mode_i |=> test_sdi_o == $past(ground_sense_pin_i) && gnd_filter_cnt_o == '0)
    else $error("Test data input not routed.");

  a_adc_pin_sel: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !test_mode_i |=> !adc_from_pin_o)
    else $error("Converter driven from pin outside test mode.");

  a_tick_rate: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    osc_tick |=> !osc_tick [*8])
    else $error("Oscillator tick too frequent.");

  a_tick_gap: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    osc_tick |-> ##[1:32] osc_tick)
    else $error("Oscillator tick too slow.");

  a_clear_unlatch: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    clear_req && !fault_now |=> !status_flag_o && !ground_fault_flag_o)
    else $error("Clear command did not clear the flags.");

  a_lockout_break: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmd_take && cmd_code_i != GFLM_CMD_SELFTEST_LOCKOUT && !selftest_lockout_o |=> !selftest_lockout_o)
    else $error("Lockout set by another command.");

  a_lockout_set: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmd_take && cmd_code_i == GFLM_CMD_SELFTEST_LOCKOUT && q.prev_selftest_lockout |=> selftest_lockout_o)
    else $error("Second disable command did not lock out.");

  a_ignore_cmds: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmd_ignore_o && cmd_valid_i |=> !selftest_lockout_o && bus_switch_open_o)
    else $error("Command taken while ignored.");

  a_reset_entry: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rst_cond |=> dev_reset_o)
    else $error("Reset condition did not hold the device.");

  a_held_release: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    dev_reset_o && !rst_cond |=> !dev_reset_o)
    else $error("Device stuck in reset.");

  a_frame_timer: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !bus_below_frame_i |=> q.frame_cnt == '0)
    else $error("Frame timer not restarted.");

  a_uv_flag_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !hold_capacitor_node_uv_i |=> !low_voltage_flag_o)
    else $error("Low-voltage flag stuck.");

  a_run_stays: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !rst_cond && !dev_reset_o |=> !dev_reset_o)
    else $error("Device reset without a reset condition.");

  a_fault_follows: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !fault_now && !selftest_lockout_o |=> !status_flag_o)
    else $error("Status flag latched without lockout.");

  a_gf_follows: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !gnd_loss && !selftest_lockout_o |=> !ground_fault_flag_o)
    else $error("Ground flag latched without lockout.");

  a_switch_close: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmd_take && switch_close_i |=> !bus_switch_open_o)
    else $error("Switch did not close on command.");

  a_reply_zeroed: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    low_voltage_flag_o || status_flag_o || ground_fault_flag_o |-> accel_o == `GFLM_ACCEL_ZERO)
    else $error("Reply not zero with a flag set.");

  a_adc_pin_test: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    test_mode_i && filter_monitor_pin_adc_sel_i |=> adc_from_pin_o)
    else $error("Converter not switched to the pin.");

  a_sdi_idle: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !test_mode_i |=> !test_sdi_o)
    else $error("Test data input active outside test mode.");

  a_ground_cfg_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !config_byte_two_i[`GFLM_GROUND_LOSS_ENABLE_BIT_BIT] |=> gnd_filter_cnt_o == '0 && !gnd_loss)
    else $error("Ground detection active while not enabled.");

endmodule : gflm_monitor

`default_nettype wire

/* sim/gflm_master_model.sv */
// Behavioural bus master that hands decoded commands to the monitor.
// Assumes the bench calls send only after reset has been released.
`timescale 1ns/10ps
`default_nettype none

module gflm_master_model
  import gflm_pkg::*;
(
  input wire logic mclk_i,
  output logic cmd_valid_o,
  output var gflm_cmd_t cmd_code_o,
  output logic switch_close_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_code_o = GFLM_CMD_OTHER;
    switch_close_o = 1'b0;
  end

  // Drives one command for one cycle; with last low the next call follows back to back.
  // Released lines show the inverse of the last value, so stale data is never trusted.
  task automatic send(input gflm_cmd_t c, input logic cl, input logic last);
    @(posedge mclk_i);
    cmd_valid_o <= 1'b1;
    cmd_code_o <= c;
    switch_close_o <= cl;
    if (last) begin
      @(posedge mclk_i);
      cmd_valid_o <= 1'b0;
      cmd_code_o <= gflm_cmd_t'(~c);
      switch_close_o <= ~cl;
    end
  endtask : send
endmodule : gflm_master_model

`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the fault supervision monitor.
// Assumes the package, the monitor and the master model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import gflm_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic tm = 0, dm = 0, gs = 0, cs = 0, ruv = 0, huv = 0, bbf = 0;
  logic fuse = 0, p1 = 0, p2 = 0;
  logic [7:0] cfg = 8'h00;
  logic [9:0] acc_i = 10'h000;
  logic cv, sc;
  gflm_cmd_t cc;
  logic [9:0] acc_o;
  logic dr, ci, so, lv, sf, gf, lo, sdi, afp;
  logic [13:0] cnt;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  int i, k;

  always #4 mclk_i = ~mclk_i;

  gflm_monitor #(.HOLD_CAPACITOR_NODE_CYC(50), .FRAME_CYC(50), .GF_TOP(14'h0007)) uut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .test_mode_i(tm), .diff_mode_i(dm),
    .config_byte_two_i(cfg), .ground_sense_pin_i(gs), .filter_monitor_pin_adc_sel_i(cs),
    .regulator_cap_node_uv_i(ruv), .hold_capacitor_node_uv_i(huv),
    .bus_below_frame_i(bbf), .fuse_fault_i(fuse), .par1_fault_i(p1), .par2_fault_i(p2),
    .cmd_valid_i(cv), .cmd_code_i(cc), .switch_close_i(sc), .accel_i(acc_i),
    .accel_o(acc_o), .dev_reset_o(dr), .cmd_ignore_o(ci), .bus_switch_open_o(so),
    .low_voltage_flag_o(lv), .status_flag_o(sf), .ground_fault_flag_o(gf),
    .selftest_lockout_o(lo), .test_sdi_o(sdi), .adc_from_pin_o(afp),
    .gnd_filter_cnt_o(cnt)
  );

  gflm_master_model master (
    .mclk_i(mclk_i), .cmd_valid_o(cv), .cmd_code_o(cc), .switch_close_o(sc)
  );

  task cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : cyc

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task end_of_test;
    if (miscompares == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  task wait_gf(input logic e);
    for (i = 0; i < 700 && gf !== e; i++) @(posedge mclk_i);
  endtask : wait_gf

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      end_of_test();
    end
  end

  initial begin
    cyc(2);
    #1;
    chk({dr, so, lv, sf, gf, lo}, 6'h30);
    cyc(1);
    rst_n_i <= 1'b1;
    acc_i <= 10'h2a5;
    cyc(4);
    #1;
    chk({dr, so}, 2'h1);
    chk(acc_o, 10'h2a5);
    for (k = 0; k < 3; k++) begin
      cyc(1);
      {fuse, p1, p2} <= 3'h4 >> k;
      cyc(2);
      #1;
      chk({sf, gf, acc_o}, 12'h800);
      cyc(1);
      {fuse, p1, p2} <= 3'h0;
      cyc(2);
      #1;
      chk({sf, acc_o}, 11'h2a5);
    end
    cyc(1);
    huv <= 1'b1;
    cyc(10);
    #1;
    chk({lv, dr, acc_o}, 12'h800);
    cyc(1);
    huv <= 1'b0;
    cyc(3);
    for (k = 0; k < 3; k++) begin
      master.send(GFLM_CMD_OTHER, 1'b1, 1'b1);
      cyc(2);
      #1;
      chk(so, 1'b0);
      cyc(1);
      {ruv, huv, bbf} <= 3'h4 >> k;
      cyc(60);
      #1;
      chk({dr, so, ci, acc_o}, 13'h1c00);
      master.send(GFLM_CMD_SELFTEST_LOCKOUT, 1'b0, 1'b0);
      master.send(GFLM_CMD_SELFTEST_LOCKOUT, 1'b0, 1'b1);
      cyc(1);
      {ruv, huv, bbf} <= 3'h0;
      cyc(4);
      #1;
      chk({dr, lo, ci}, 3'h0);
    end
    cyc(1);
    cfg <= 8'h20;
    gs <= 1'b1;
    for (i = 0; i < 40 && cnt === 14'h0; i++) @(posedge mclk_i);
    #1;
    chk(cnt, 14'h1);
    wait_gf(1'b1);
    #1;
    chk({sf, gf, acc_o}, 12'hc00);
    chk(cnt, 14'h7);
    chk(i > 150, 1'b1);
    cyc(1);
    gs <= 1'b0;
    wait_gf(1'b0);
    #1;
    chk(i > 150, 1'b1);
    chk({sf, cnt}, 15'h0);
    cyc(100);
    #1;
    chk({gf, cnt}, 15'h0);
    for (k = 0; k < 3; k++) begin
      cyc(1);
      cfg <= (k == 0) ? 8'hdf : 8'h20;
      dm <= (k == 1);
      tm <= (k == 2);
      cs <= 1'b1;
      gs <= 1'b1;
      cyc(300);
      #1;
      chk({gf, cnt}, 15'h0);
      chk({sdi, afp}, (k == 2) ? 2'h3 : 2'h0);
      cyc(1);
      gs <= 1'b0;
      cs <= 1'b0;
      cyc(2);
      #1;
      chk({sdi, afp}, 2'h0);
    end
    cyc(1);
    tm <= 1'b0;
    dm <= 1'b0;
    cyc(2);
    master.send(GFLM_CMD_SELFTEST_LOCKOUT, 1'b0, 1'b0);
    master.send(GFLM_CMD_STEN, 1'b0, 1'b0);
    master.send(GFLM_CMD_SELFTEST_LOCKOUT, 1'b0, 1'b1);
    cyc(1);
    #1;
    chk(lo, 1'b0);
    master.send(GFLM_CMD_SELFTEST_LOCKOUT, 1'b0, 1'b1);
    cyc(2);
    #1;
    chk(lo, 1'b1);
    cyc(1);
    fuse <= 1'b1;
    cyc(2);
    fuse <= 1'b0;
    cyc(6);
    #1;
    chk({lo, sf}, 2'h3);
    master.send(GFLM_CMD_CLEAR, 1'b0, 1'b1);
    cyc(2);
    #1;
    chk({lo, sf, acc_o}, 12'haa5);
    cyc(1);
    fuse <= 1'b1;
    cyc(2);
    fuse <= 1'b0;
    rst_n_i <= 1'b0;
    cyc(2);
    #1;
    chk({dr, lo, sf, acc_o}, 13'h1000);
    cyc(1);
    rst_n_i <= 1'b1;
    cyc(3);
    #1;
    chk({dr, lo, sf, acc_o}, 13'h02a5);
    end_of_test();
  end
endmodule : testbench

`default_nettype wire
